// ===== design/lsi_cfg.svh
`ifndef LSI_CFG_SVH
`define LSI_CFG_SVH

// ****************************************
// bus address and command codes
// ****************************************
`define LSI_ADDR 7'h29
`define LSI_CMD_CONF 8'h00
`define LSI_CMD_UPPER 8'h01
`define LSI_CMD_LOWER 8'h02
`define LSI_CMD_PSAVE 8'h03
`define LSI_CMD_AMB 8'h04
`define LSI_CMD_WHITE 8'h05
`define LSI_CMD_INTF 8'h06

// ****************************************
// field positions and reset values
// ****************************************
`define LSI_SD_BIT 0
`define LSI_INTEN_BIT 1
`define LSI_INTCH_BIT 3
`define LSI_IFL_BIT 15
`define LSI_IFH_BIT 14
`define LSI_PSAVE_W 3
`define LSI_CONF_RST 16'h0001
`define LSI_WORD_RST 16'h0000
`define LSI_BIT_ACK 4'h8
`define LSI_BIT_LAST 4'h7

// ****************************************
// timing
// ****************************************
`define LSI_CLK_MHZ 250
`define LSI_TMO_MS 25
`define LSI_TMO_CYC (`LSI_TMO_MS * `LSI_CLK_MHZ * 1000)

`endif

// ===== design/lsi_pkg.sv
`default_nettype none

package lsi_pkg;
    typedef logic [15:0] lsi_word_t;
    typedef logic [7:0] lsi_byte_t;
endpackage

`default_nettype wire

// ===== design/lsi_target.sv
`include "lsi_cfg.svh"
`default_nettype none

module lsi_target
    import lsi_pkg::*;
#(
    parameter int unsigned TMO_CYCLES = `LSI_TMO_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output logic int_o,
    output logic int_oe_n,
    input wire logic meas_valid_i,
    input wire logic [15:0] meas_ambient_i,
    input wire logic [15:0] meas_white_i,
    output lsi_word_t sensor_config,
    output logic [`LSI_PSAVE_W-1:0] power_save
);

    // ****************************************
    // link side, clocked by the bus clock
    // ****************************************
    logic lrst_r;
    logic [3:0] bit_cnt_r;
    lsi_byte_t shift_r;
    logic first_r;
    logic match_r;
    logic rd_r;
    logic ack_pend_r;
    logic nack_r;
    logic rx_tog_r;
    logic rd_tog_r;
    lsi_byte_t rx_byte_r;
    lsi_byte_t tx_byte_r;
    lsi_byte_t byte_w;

    assign byte_w = {shift_r[6:0], sda_i};

    always_ff @(posedge scl or posedge lrst_r) begin
        if (lrst_r) begin
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            first_r <= 1'b1;
            match_r <= 1'b0;
            rd_r <= 1'b0;
            ack_pend_r <= 1'b0;
            nack_r <= 1'b0;
        end else begin
            bit_cnt_r <= (bit_cnt_r == `LSI_BIT_ACK) ? 4'h0 :
                         bit_cnt_r + 4'h1;
            if (bit_cnt_r != `LSI_BIT_ACK) begin
                shift_r <= byte_w;
            end
            ack_pend_r <= 1'b0;
            if (bit_cnt_r == `LSI_BIT_LAST) begin
                if (first_r) begin
                    match_r <= (byte_w[7:1] == `LSI_ADDR);
                    ack_pend_r <= (byte_w[7:1] == `LSI_ADDR);
                    rd_r <= byte_w[0];
                    first_r <= 1'b0;
                end else begin
                    ack_pend_r <= match_r & ~rd_r;
                end
            end
            if (bit_cnt_r == `LSI_BIT_ACK && match_r && rd_r &&
                !ack_pend_r) begin
                nack_r <= nack_r | sda_i;
            end
        end
    end

    // byte events toward the core side; never reset by a frame
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            rx_tog_r <= 1'b0;
            rd_tog_r <= 1'b0;
            rx_byte_r <= 8'h00;
        end else begin
            if (bit_cnt_r == `LSI_BIT_LAST && !first_r && match_r &&
                !rd_r && !lrst_r) begin
                rx_tog_r <= ~rx_tog_r;
                rx_byte_r <= byte_w;
            end
            if (bit_cnt_r == `LSI_BIT_ACK && match_r && rd_r &&
                !ack_pend_r && !nack_r && !lrst_r) begin
                rd_tog_r <= ~rd_tog_r;
            end
        end
    end

    // acknowledge and read data drive on falling edge
    always_ff @(negedge scl or posedge lrst_r) begin
        if (lrst_r) begin
            sda_oe_n <= 1'b1;
        end else if (bit_cnt_r == `LSI_BIT_ACK) begin
            sda_oe_n <= ~ack_pend_r;
        end else if (match_r && rd_r && !nack_r) begin
            sda_oe_n <= tx_byte_r[3'(3'd7 - bit_cnt_r[2:0])];
        end else begin
            sda_oe_n <= 1'b1;
        end
    end

    // ****************************************
    // core side: bus watch and crossings
    // ****************************************
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic rx_s1, rx_s2, rx_s3;
    logic rd_s1, rd_s2, rd_s3;
    logic rx_ev, rd_ev;
    logic [22:0] tmo_cnt_r;
    logic tmo_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
            {rx_s1, rx_s2, rx_s3} <= 3'h0;
            {rd_s1, rd_s2, rd_s3} <= 3'h0;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {scl, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
            {rx_s1, rx_s2, rx_s3} <= {rx_tog_r, rx_s1, rx_s2};
            {rd_s1, rd_s2, rd_s3} <= {rd_tog_r, rd_s1, rd_s2};
        end
    end

    assign rx_ev = rx_s2 ^ rx_s3;
    assign rd_ev = rd_s2 ^ rd_s3;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmo_cnt_r <= 23'h0;
            tmo_r <= 1'b0;
        end else if (scl_s2 && sda_s2) begin
            tmo_cnt_r <= 23'h0;
            tmo_r <= 1'b0;
        end else if (tmo_cnt_r == 23'(TMO_CYCLES - 1)) begin
            tmo_r <= 1'b1;
        end else begin
            tmo_cnt_r <= tmo_cnt_r + 23'h1;
        end
    end

    // frame reset on start, stop or timeout
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lrst_r <= 1'b1;
        end else begin
            lrst_r <= (scl_s2 && scl_s3 && (sda_s2 ^ sda_s3)) || tmo_r;
        end
    end

    // ****************************************
    // register file
    // ****************************************
    lsi_byte_t cmd_r;
    lsi_byte_t lo_r;
    logic [1:0] wr_idx_r;
    logic rd_hi_r;
    lsi_word_t upper_threshold_r;
    lsi_word_t lower_threshold_r;
    lsi_word_t ambient_result_r;
    lsi_word_t white_result_r;
    logic flag_lo_r, flag_hi_r;
    logic wr_commit;
    lsi_word_t cmp_val;

    assign wr_commit = rx_ev && (wr_idx_r == 2'd2);
    assign cmp_val = sensor_config[`LSI_INTCH_BIT] ? meas_white_i :
                     meas_ambient_i;

    function automatic lsi_word_t rd_word(input lsi_byte_t code);
        lsi_word_t w;
        w = 16'h0000;
        unique case (code)
            `LSI_CMD_CONF: w = sensor_config;
            `LSI_CMD_UPPER: w = upper_threshold_r;
            `LSI_CMD_LOWER: w = lower_threshold_r;
            `LSI_CMD_PSAVE: w = {13'h0, power_save};
            `LSI_CMD_AMB: w = ambient_result_r;
            `LSI_CMD_WHITE: w = white_result_r;
            `LSI_CMD_INTF: begin
                w[`LSI_IFL_BIT] = flag_lo_r;
                w[`LSI_IFH_BIT] = flag_hi_r;
            end
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    // word selected for the read path
    lsi_word_t rd_val;

    always_comb begin
        rd_val = rd_word(cmd_r);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_idx_r <= 2'd0;
            cmd_r <= 8'h00;
            lo_r <= 8'h00;
        end else if (lrst_r) begin
            wr_idx_r <= 2'd0;
        end else if (rx_ev) begin
            unique case (wr_idx_r)
                2'd0: cmd_r <= rx_byte_r;
                2'd1: lo_r <= rx_byte_r;
                default: ;
            endcase
            wr_idx_r <= (wr_idx_r == 2'd2) ? 2'd1 : wr_idx_r + 2'd1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sensor_config <= `LSI_CONF_RST;
            upper_threshold_r <= `LSI_WORD_RST;
            lower_threshold_r <= `LSI_WORD_RST;
            power_save <= '0;
        end else if (wr_commit) begin
            unique case (cmd_r)
                `LSI_CMD_CONF: sensor_config <= {rx_byte_r, lo_r};
                `LSI_CMD_UPPER: upper_threshold_r <= {rx_byte_r, lo_r};
                `LSI_CMD_LOWER: lower_threshold_r <= {rx_byte_r, lo_r};
                `LSI_CMD_PSAVE: power_save <= lo_r[`LSI_PSAVE_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ambient_result_r <= `LSI_WORD_RST;
            white_result_r <= `LSI_WORD_RST;
        end else if (meas_valid_i && !sensor_config[`LSI_SD_BIT]) begin
            ambient_result_r <= meas_ambient_i;
            white_result_r <= meas_white_i;
        end
    end

    // crossing flags, clear on read, set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_lo_r <= 1'b0;
            flag_hi_r <= 1'b0;
        end else begin
            if (rd_ev && rd_hi_r && cmd_r == `LSI_CMD_INTF) begin
                flag_lo_r <= 1'b0;
                flag_hi_r <= 1'b0;
            end
            if (meas_valid_i && !sensor_config[`LSI_SD_BIT] &&
                sensor_config[`LSI_INTEN_BIT]) begin
                if (cmp_val < lower_threshold_r) begin
                    flag_lo_r <= 1'b1;
                end
                if (cmp_val > upper_threshold_r) begin
                    flag_hi_r <= 1'b1;
                end
            end
        end
    end

    // read path has no shutdown gating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_hi_r <= 1'b0;
            tx_byte_r <= 8'hFF;
        end else begin
            if (lrst_r) begin
                rd_hi_r <= 1'b0;
            end else if (rd_ev) begin
                rd_hi_r <= ~rd_hi_r;
            end
            tx_byte_r <= rd_hi_r ? rd_val[15:8] : rd_val[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_oe_n <= 1'b1;
            int_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            int_oe_n <= ~(flag_lo_r | flag_hi_r);
            int_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_addr_match;
        @(posedge scl) disable iff (lrst_r)
        (bit_cnt_r == `LSI_BIT_LAST && first_r) |=>
            (match_r == ($past(byte_w[7:1]) == `LSI_ADDR));
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("address match wrong");

    property p_dir;
        @(posedge scl) disable iff (lrst_r)
        (bit_cnt_r == `LSI_BIT_LAST && first_r) |=> rd_r == $past(sda_i);
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction bit wrong");

    property p_ack;
        @(posedge scl) disable iff (lrst_r)
        (bit_cnt_r == `LSI_BIT_ACK && ack_pend_r) |-> !sda_oe_n;
    endproperty
    a_ack: assert property (p_ack)
        else $error("missing acknowledge");

    property p_tmo;
        @(posedge clk) disable iff (rst)
        $rose(tmo_r) |=> lrst_r [*2];
    endproperty
    a_tmo: assert property (p_tmo)
        else $error("timeout did not abandon frame");

    property p_hold;
        @(posedge clk) disable iff (rst)
        sensor_config[`LSI_SD_BIT] |=> $stable(ambient_result_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result changed in shutdown");

    property p_refresh;
        @(posedge clk) disable iff (rst)
        (meas_valid_i && !sensor_config[`LSI_SD_BIT]) |=>
            ambient_result_r == $past(meas_ambient_i);
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("result not refreshed");

    property p_ro;
        @(posedge clk) disable iff (rst)
        (wr_commit && cmd_r >= `LSI_CMD_AMB && !meas_valid_i) |=>
            $stable(ambient_result_r) && $stable(white_result_r);
    endproperty
    a_ro: assert property (p_ro)
        else $error("result register written");

    property p_conf_wr;
        @(posedge clk) disable iff (rst)
        (wr_commit && cmd_r == `LSI_CMD_CONF) |=>
            sensor_config == {$past(rx_byte_r), $past(lo_r)};
    endproperty
    a_conf_wr: assert property (p_conf_wr)
        else $error("config write lost");

    property p_flag_rd;
        @(posedge clk) disable iff (rst)
        (rd_hi_r && cmd_r == `LSI_CMD_INTF) |=>
            tx_byte_r[7:6] == {$past(flag_lo_r), $past(flag_hi_r)};
    endproperty
    a_flag_rd: assert property (p_flag_rd)
        else $error("flag byte wrong");

    property p_int;
        @(posedge clk) disable iff (rst)
        (flag_lo_r || flag_hi_r) |=> !int_oe_n && int_o == 1'b0;
    endproperty
    a_int: assert property (p_int)
        else $error("interrupt not pulled low");

endmodule

`default_nettype wire

// ===== tb/lsi_host.sv
`default_nettype none

// ****************************************
// bus host model
// ****************************************
module lsi_host
    import lsi_pkg::*;
(
    input wire logic lclk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 4;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge lclk);
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_pull <= ~b;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        s = sda;
        scl <= 1'b0;
        tick(1);
    endtask
    task automatic start();
        sda_pull <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_pull <= 1'b1;
        tick(HALF);
        scl <= 1'b0;
        tick(1);
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_pull <= 1'b0;
        tick(HALF);
    endtask
    task automatic wbyte(input lsi_byte_t b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = (s === 1'b0);
    endtask
    task automatic rbyte(output lsi_byte_t b, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(last, s);
    endtask
    task automatic wr(input lsi_byte_t cmd, input lsi_word_t d,
                      output logic ok);
        logic a0, a1, a2, a3;
        start();
        wbyte(8'h52, a0);
        wbyte(cmd, a1);
        wbyte(d[7:0], a2);
        wbyte(d[15:8], a3);
        stop();
        ok = a0 & a1 & a2 & a3;
    endtask
    task automatic rd(input lsi_byte_t cmd, output lsi_word_t d,
                      output logic ok);
        logic a0, a1, a2;
        lsi_byte_t lo, hi;
        start();
        wbyte(8'h52, a0);
        wbyte(cmd, a1);
        start();
        wbyte(8'h53, a2);
        rbyte(lo, 1'b0);
        rbyte(hi, 1'b1);
        stop();
        d = {hi, lo};
        ok = a0 & a1 & a2;
    endtask
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none

module tb_top import lsi_pkg::*; ();
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        lsi_byte_t cmd;
        lsi_word_t wd;
        lsi_word_t rx;
    } lsi_row_t;
    logic clk, rst, lclk, scl, sda_i, sda_o, sda_oe_n, int_o, int_oe_n;
    logic host_pull, int_line, meas_valid, ack;
    lsi_word_t meas_amb, meas_white, sensor_config;
    logic [2:0] power_save;
    int fails = 0;
    int n_compared = 0;
    lsi_row_t rows [9] = '{
        '{8'h01, 16'hA55A, 16'hA55A}, '{8'h02, 16'h0F0F, 16'h0F0F},
        '{8'h03, 16'hFFFF, 16'h0007}, '{8'h00, 16'h0009, 16'h0009},
        '{8'h04, 16'h1234, 16'h0000}, '{8'h05, 16'h1234, 16'h0000},
        '{8'h06, 16'hFFFF, 16'h0000}, '{8'h07, 16'hBEEF, 16'h0000},
        '{8'h00, 16'h0009, 16'h0009}};
    assign sda_i = ~host_pull & (sda_oe_n | sda_o);
    assign int_line = int_oe_n ? 1'b1 : int_o;
    always #2 clk = ~clk;
    initial begin
        lclk = 1'b0;
        #1.3;
        forever #3 lclk = ~lclk;
    end
    lsi_host host (.lclk(lclk), .sda(sda_i), .scl(scl),
                   .sda_pull(host_pull));
    lsi_target #(.TMO_CYCLES(400)) uut (.clk(clk), .rst(rst), .scl(scl),
        .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .int_o(int_o),
        .int_oe_n(int_oe_n), .meas_valid_i(meas_valid),
        .meas_ambient_i(meas_amb), .meas_white_i(meas_white),
        .sensor_config(sensor_config), .power_save(power_save));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input lsi_word_t seen, input lsi_word_t exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr_chk(input lsi_byte_t c, input lsi_word_t d);
        logic ok;
        host.wr(c, d, ok);
        chk(16'(ok), 16'h0001);
    endtask
    task automatic rd_chk(input lsi_byte_t c, input lsi_word_t exp);
        logic ok;
        lsi_word_t d;
        host.rd(c, d, ok);
        chk(16'(ok), 16'h0001);
        chk(d, exp);
    endtask
    task automatic meas(input lsi_word_t a, input lsi_word_t w);
        @(posedge clk) #1;
        meas_valid = 1'b1;
        meas_amb = a;
        meas_white = w;
        @(posedge clk) #1;
        meas_valid = 1'b0;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        #400000;
        fails++;
        test_done();
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        meas_valid = 1'b0;
        meas_amb = 16'h0000;
        meas_white = 16'h0000;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        repeat (8) @(posedge clk);
        chk(sensor_config, 16'h0001);
        chk({13'h0000, power_save}, 16'h0000);
        chk({14'h0000, sda_oe_n, int_line}, 16'h0003);
        $display("test reset done");
        foreach (rows[i]) begin
            wr_chk(rows[i].cmd, rows[i].wd);
            rd_chk(rows[i].cmd, rows[i].rx);
        end
        chk(sensor_config, 16'h0009);
        chk({13'h0000, power_save}, 16'h0007);
        $display("test table done");
        host.start();
        host.wbyte(8'h54, ack);
        host.stop();
        chk(16'(ack), 16'h0000);
        $display("test address done");
        meas(16'h3333, 16'h3333);
        rd_chk(8'h04, 16'h0000);
        wr_chk(8'h01, 16'h1000);
        wr_chk(8'h02, 16'h0100);
        wr_chk(8'h00, 16'h0002);
        meas(16'h2000, 16'h0050);
        chk(16'(int_line), 16'h0000);
        rd_chk(8'h04, 16'h2000);
        rd_chk(8'h05, 16'h0050);
        rd_chk(8'h06, 16'h4000);
        repeat (4) @(posedge clk);
        chk(16'(int_line), 16'h0001);
        meas(16'h0010, 16'h0000);
        rd_chk(8'h06, 16'h8000);
        wr_chk(8'h00, 16'h0003);
        meas(16'h0777, 16'h0777);
        rd_chk(8'h04, 16'h0010);
        $display("test shutdown done");
        host.start();
        host.wbyte(8'h52, ack);
        host.wbyte(8'h00, ack);
        host.start();
        host.wbyte(8'h53, ack);
        repeat (2) @(posedge clk);
        chk(16'(sda_oe_n), 16'h0000);
        repeat (450) @(posedge clk);
        chk(16'(sda_oe_n), 16'h0001);
        host.stop();
        rd_chk(8'h00, 16'h0003);
        $display("test timeout done");
        wr_chk(8'h00, 16'h000A);
        meas(16'h0050, 16'h2000);
        rd_chk(8'h06, 16'h4000);
        rd_chk(8'h04, 16'h0050);
        $display("test channel done");
        test_done();
    end
endmodule

`default_nettype wire
